// *** rtl/mssc_bank.v ***
// register bank for egress mirror sampling and protocol snooping
// assumes a single-cycle strobe register port and frame info on sys_clk
//
// Overview of operation
// RQ1: enabled sampling mirrors one in divisor+1
// RQ2: sampling counts only filter-passing frames
// RQ3: 48-bit match address compared per mode
// RQ4: fixed read-only part identifier word
// RQ5: fixed read-only silicon revision byte
// RQ6: bit 17 enables MLD query snooping
// RQ7: bit 18 traps MLD query to CPU
// RQ8: bit 15 enables MLD report/done snooping
// RQ9: bit 16 traps MLD report/done to CPU
// RQ10: bit 13 enables IGMP unknown snooping
// RQ11: bit 14 traps IGMP unknown to CPU
// RQ12: bit 11 enables IGMP query snooping
// RQ13: bit 12 traps IGMP query to CPU
// RQ14: match mode: all, DA, SA, reserved
// RQ15: control bit 13 enables the divisor
// RQ16: trap bit only matters when enabled
// RQ17: divisor or enable change restarts count
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`include "mssc_defs.vh"
module mssc_bank (
  input wire sys_clk,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire frame_valid,
  input wire [47:0] frame_da,
  input wire [47:0] frame_sa,
  input wire frame_port_sel,
  input wire is_igmp_query,
  input wire is_igmp_unknown,
  input wire is_mld_query,
  input wire is_mld_report_done,
  output reg mirror_out,
  output reg copy_to_cpu,
  output reg cpu_only
);
  // ****************************************
  // registers
  // ****************************************
  reg [15:0] mirror_ctrl_q;
  reg [9:0] divisor_q;
  reg [47:0] egress_match_address_q;
  reg [31:0] snoop_q;
  reg [31:0] rdata_d;
  wire [31:0] part_identifier;
  wire [7:0] silicon_revision;
  // RQ4 fixed identifier, arbitrary value
  assign part_identifier = `MSSC_PART_ID_VAL;
  // RQ5 fixed revision, arbitrary value
  assign silicon_revision = `MSSC_REVISION_VAL;
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      mirror_ctrl_q <= `MSSC_RST_MIRROR_CTRL;
      divisor_q <= `MSSC_RST_DIVISOR;
      egress_match_address_q <= `MSSC_RST_MATCH;
      snoop_q <= `MSSC_RST_SNOOP;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `MSSC_OFF_MIRROR_CTRL: mirror_ctrl_q <= reg_wdata[15:0];
        `MSSC_OFF_DIVISOR: divisor_q <= reg_wdata[`MSSC_DIV_MSB:0];
        // RQ3 match address store
        `MSSC_OFF_MATCH_LO: egress_match_address_q[31:0] <= reg_wdata;
        `MSSC_OFF_MATCH_HI: egress_match_address_q[47:32] <= reg_wdata[15:0];
        `MSSC_OFF_SNOOP: snoop_q <= {13'h0000, reg_wdata[`MSSC_SNOOP_MSB:0]};
        default: ;
      endcase
    end
  end
  // ****************************************
  // read port
  // ****************************************
  always @*
  begin
    rdata_d = 32'h00000000;
    case (reg_addr)
      `MSSC_OFF_MIRROR_CTRL: rdata_d = {16'h0000, mirror_ctrl_q};
      `MSSC_OFF_DIVISOR: rdata_d = {22'h000000, divisor_q};
      `MSSC_OFF_MATCH_LO: rdata_d = egress_match_address_q[31:0];
      `MSSC_OFF_MATCH_HI: rdata_d = {16'h0000, egress_match_address_q[47:32]};
      `MSSC_OFF_PART_ID: rdata_d = part_identifier;
      `MSSC_OFF_REVISION: rdata_d = {24'h000000, silicon_revision};
      `MSSC_OFF_SNOOP: rdata_d = snoop_q;
      default: rdata_d = 32'h00000000;
    endcase
  end
  always @(posedge sys_clk)
  begin
    if (rst)
      reg_rdata <= 32'h00000000;
    else if (reg_rd)
      reg_rdata <= rdata_d;
    else
      reg_rdata <= 32'h00000000;
  end
  // ****************************************
  // egress mirror filter and sampler
  // ****************************************
  wire [1:0] filt_mode;
  reg filt_pass;
  wire samp_pass;
  assign filt_mode = mirror_ctrl_q[`MSSC_FILT_MSB:`MSSC_FILT_LSB];
  // RQ14 match mode select
  always @*
  begin
    case (filt_mode)
      `MSSC_FILT_ALL: filt_pass = 1'b1;
      // RQ3 destination and source compare
      `MSSC_FILT_DA: filt_pass = (frame_da == egress_match_address_q);
      `MSSC_FILT_SA: filt_pass = (frame_sa == egress_match_address_q);
      default: filt_pass = 1'b0;
    endcase
  end
  // RQ2 only filtered frames counted
  // RQ15 divisor enable bit
  // RQ1 one in n sampler
  // RQ17 restart on change
  mssc_sampler u_sampler (
    .sys_clk(sys_clk),
    .rst(rst),
    .div_enable(mirror_ctrl_q[`MSSC_DIV_EN_BIT]),
    .divisor(divisor_q),
    .qualify(frame_valid & frame_port_sel & filt_pass),
    .pass(samp_pass)
  );
  // ****************************************
  // protocol snooping
  // ****************************************
  wire [3:0] cls_copy;
  wire [3:0] cls_only;
  // RQ12 RQ13 IGMP query
  mssc_snoop_decide u_igmp_qry (
    .snoop_enable(snoop_q[`MSSC_BIT_IGMP_QUERY_SNOOP_ENABLE]),
    .trap_only(snoop_q[`MSSC_BIT_IGMP_QRY_TRAP]),
    .class_hit(is_igmp_query),
    .copy_to_cpu(cls_copy[0]),
    .cpu_only(cls_only[0])
  );
  // RQ10 RQ11 IGMP unknown
  mssc_snoop_decide u_igmp_ukn (
    .snoop_enable(snoop_q[`MSSC_BIT_IGMP_UNKNOWN_SNOOP_ENABLE]),
    .trap_only(snoop_q[`MSSC_BIT_IGMP_UKN_TRAP]),
    .class_hit(is_igmp_unknown),
    .copy_to_cpu(cls_copy[1]),
    .cpu_only(cls_only[1])
  );
  // RQ8 RQ9 MLD report/done
  mssc_snoop_decide u_mld_rd (
    .snoop_enable(snoop_q[`MSSC_BIT_MLD_RD_EN]),
    .trap_only(snoop_q[`MSSC_BIT_MLD_RD_TRAP]),
    .class_hit(is_mld_report_done),
    .copy_to_cpu(cls_copy[2]),
    .cpu_only(cls_only[2])
  );
  // RQ6 RQ7 MLD query
  mssc_snoop_decide u_mld_qry (
    .snoop_enable(snoop_q[`MSSC_BIT_MLD_QUERY_SNOOP_ENABLE]),
    .trap_only(snoop_q[`MSSC_BIT_MLD_QRY_TRAP]),
    .class_hit(is_mld_query),
    .copy_to_cpu(cls_copy[3]),
    .cpu_only(cls_only[3])
  );
  // RQ16 decisions registered
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      mirror_out <= 1'b0;
      copy_to_cpu <= 1'b0;
      cpu_only <= 1'b0;
    end
    else
    begin
      mirror_out <= samp_pass;
      cpu_only <= frame_valid & (|cls_only);
      copy_to_cpu <= frame_valid & (|cls_copy) & ~(|cls_only);
    end
  end
endmodule // mssc_bank

// *** rtl/mssc_defs.vh ***
// constants for the mirror sampling and snoop control bank
// assumes inclusion by bare name from design files
`ifndef MSSC_DEFS_VH
`define MSSC_DEFS_VH
`define MSSC_ADDR_W 8
`define MSSC_OFF_DIVISOR 8'h1E
`define MSSC_OFF_MATCH_LO 8'h20
`define MSSC_OFF_MATCH_HI 8'h24
`define MSSC_OFF_PART_ID 8'h30
`define MSSC_OFF_REVISION 8'h40
`define MSSC_OFF_SNOOP 8'h50
`define MSSC_OFF_MIRROR_CTRL 8'h1C
`define MSSC_RST_DIVISOR 10'h000
`define MSSC_RST_MATCH 48'h000000000000
`define MSSC_RST_SNOOP 32'h00000000
`define MSSC_RST_MIRROR_CTRL 16'h0000
`define MSSC_DIV_MSB 9
`define MSSC_FILT_LSB 14
`define MSSC_FILT_MSB 15
`define MSSC_DIV_EN_BIT 13
`define MSSC_FILT_ALL 2'h0
`define MSSC_FILT_DA 2'h1
`define MSSC_FILT_SA 2'h2
`define MSSC_BIT_IGMP_QUERY_SNOOP_ENABLE 11
`define MSSC_BIT_IGMP_QRY_TRAP 12
`define MSSC_BIT_IGMP_UNKNOWN_SNOOP_ENABLE 13
`define MSSC_BIT_IGMP_UKN_TRAP 14
`define MSSC_BIT_MLD_RD_EN 15
`define MSSC_BIT_MLD_RD_TRAP 16
`define MSSC_BIT_MLD_QUERY_SNOOP_ENABLE 17
`define MSSC_BIT_MLD_QRY_TRAP 18
`define MSSC_SNOOP_MSB 18
`define MSSC_PART_ID_VAL 32'h00A5C0DE
`define MSSC_REVISION_VAL 8'h01
`endif

// *** rtl/mssc_snoop_decide.v ***
// one message class: snoop enable plus trap mode to delivery choice
// assumes class match comes from the frame classifier on the same clock
`timescale 1ns/1ps
module mssc_snoop_decide (
  input wire snoop_enable,
  input wire trap_only,
  input wire class_hit,
  output wire copy_to_cpu,
  output wire cpu_only
);
  // mode bit only counts while enabled
  assign copy_to_cpu = class_hit & snoop_enable & ~trap_only;
  assign cpu_only = class_hit & snoop_enable & trap_only;
endmodule // mssc_snoop_decide

// *** rtl/mssc_sampler.v ***
// egress mirror one-in-n sampler
// assumes qualify pulses come from the same clock
`timescale 1ns/1ps
`include "mssc_defs.vh"
module mssc_sampler (
  input wire sys_clk,
  input wire rst,
  input wire div_enable,
  input wire [9:0] divisor,
  input wire qualify,
  output wire pass
);
  reg [9:0] count_q;
  reg [9:0] count_d;
  reg [9:0] div_last_q;
  reg en_last_q;
  wire restart;
  assign restart = (divisor != div_last_q) | (div_enable != en_last_q);
  // first frame of each period passes
  assign pass = qualify & (~div_enable | restart | (count_q == 10'h000));
  always @*
  begin
    count_d = count_q;
    if (qualify)
    begin
      if (restart || count_q == divisor)
        count_d = (divisor == 10'h000 || restart) ? ((divisor == 10'h000) ? 10'h000 : 10'h001) : 10'h000;
      else
        count_d = count_q + 10'h001;
    end
    else if (restart)
      count_d = 10'h000;
  end
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      count_q <= 10'h000;
      div_last_q <= `MSSC_RST_DIVISOR;
      en_last_q <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      div_last_q <= divisor;
      en_last_q <= div_enable;
    end
  end
endmodule // mssc_sampler

// *** test/mssc_bank_sva.sv ***
// port checker for the mirror sampling and snoop bank
// assumes a bind from the bench top module
`timescale 1ns/1ps
module mssc_bank_sva (
  input logic sys_clk,
  input logic rst,
  input logic [7:0] reg_addr,
  input logic reg_rd,
  input logic [31:0] reg_rdata,
  input logic frame_valid,
  input logic frame_port_sel,
  input logic is_igmp_query,
  input logic is_igmp_unknown,
  input logic is_mld_query,
  input logic is_mld_report_done,
  input logic mirror_out,
  input logic copy_to_cpu,
  input logic cpu_only
);
  // ***
  // port relations
  // ***
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire hit = is_igmp_query | is_igmp_unknown | is_mld_query | is_mld_report_done;
  chk_part_fixed: assert property (
    (reg_rd && reg_addr == 8'h30) ##1 !reg_rd |-> reg_rdata == 32'h00A5C0DE ##1 reg_rdata == 32'h0)
    else $error("bad part id read");
  chk_rev_fixed: assert property ($past(reg_rd && reg_addr == 8'h40) |-> reg_rdata == 32'h1)
    else $error("bad revision read");
  chk_div_width: assert property ($past(reg_rd && reg_addr == 8'h1E) |-> reg_rdata[15:10] == 6'h0)
    else $error("divisor high bits set");
  chk_snoop_resv: assert property ($past(reg_rd && reg_addr == 8'h50) |-> reg_rdata[31:19] == 13'h0)
    else $error("snoop high bits set");
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data without read");
  chk_mirror_cause: assert property (mirror_out |-> $past(frame_valid && frame_port_sel))
    else $error("mirror without frame");
  chk_cpu_cause: assert property (frame_valid && !hit |=> !copy_to_cpu && !cpu_only)
    else $error("cpu delivery without class");
  chk_cpu_excl: assert property (!(copy_to_cpu && cpu_only))
    else $error("copy and trap together");
endmodule // mssc_bank_sva

// *** test/mssc_bank_test.sv ***
// self-checking bench for the mirror sampling and snoop bank
// assumes sync reset and read data one cycle after the strobe
`timescale 1ns/1ps
module mssc_bank_test;
  logic sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, frame_valid = 0, frame_port_sel = 0;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [47:0] frame_da = 48'h0, frame_sa = 48'h0, m = 48'h012389ABCDEF;
  logic [3:0] cls = 4'h0;
  logic mirror_out, copy_to_cpu, cpu_only;
  int failures = 0, cmp_count = 0;
  always #2 sys_clk = ~sys_clk;
  mssc_bank u_mssc_bank (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_valid(frame_valid), .frame_da(frame_da), .frame_sa(frame_sa),
    .frame_port_sel(frame_port_sel), .is_igmp_query(cls[0]), .is_igmp_unknown(cls[1]),
    .is_mld_report_done(cls[2]), .is_mld_query(cls[3]), .mirror_out(mirror_out),
    .copy_to_cpu(copy_to_cpu), .cpu_only(cpu_only));
  // ***
  // bus and frame tasks
  // ***
  task automatic chk(string what, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] k, logic [31:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk("read data", e, reg_rdata & k);
  endtask
  task automatic fr(logic [47:0] da, logic [47:0] sa, logic ps, logic [3:0] c, logic [2:0] e);
    @(posedge sys_clk);
    frame_valid <= 1'b1;
    frame_da <= da;
    frame_sa <= sa;
    frame_port_sel <= ps;
    cls <= c;
    @(posedge sys_clk);
    frame_valid <= 1'b0;
    #1 chk("mirror copy trap", {29'h0, e}, {29'h0, mirror_out, copy_to_cpu, cpu_only});
  endtask
  // ***
  // scenarios
  // ***
  task automatic s_regs;
    rd(8'h1E, 32'hFFFFFFFF, 32'h0);
    rd(8'h20, 32'hFFFFFFFF, 32'h0);
    wr(8'h30, 32'hFFFFFFFF);
    wr(8'h40, 32'hFFFFFFFF);
    rd(8'h30, 32'hFFFFFFFF, 32'h00A5C0DE);
    rd(8'h40, 32'hFFFFFFFF, 32'h1);
    rd(8'h7C, 32'hFFFFFFFF, 32'h0);
    wr(8'h1E, 32'hFFFFFFFF);
    rd(8'h1E, 32'hFFFFFFFF, 32'h3FF);
    wr(8'h50, 32'hFFFFFFFF);
    rd(8'h50, 32'hFFFFF800, 32'h0007F800);
  endtask
  task automatic s_snoop;
    for (int k = 0; k < 4; k++)
      for (int n = 0; n < 4; n++)
      begin
        wr(8'h50, 32'(n) << (11 + 2 * k));
        fr(m, m, 1'b0, 4'h1 << k, {1'b0, n == 1, n == 3});
        fr(m, m, 1'b0, 4'h1 << ((k + 1) % 4), 3'h0);
      end
  endtask
  task automatic s_mirror;
    wr(8'h20, 32'h89ABCDEF);
    wr(8'h24, 32'h00000123);
    rd(8'h24, 32'h0000FFFF, 32'h123);
    rd(8'h20, 32'hFFFFFFFF, 32'h89ABCDEF);
    for (int md = 0; md < 4; md++)
    begin
      wr(8'h1C, 32'(md) << 14);
      fr(m, 48'h5, 1'b1, 4'h0, {md < 2, 2'b0});
      fr(48'h5, m, 1'b1, 4'h0, {md == 0 || md == 2, 2'b0});
      fr(m, m, 1'b0, 4'h0, 3'h0);
    end
    wr(8'h1E, 32'h2);
    wr(8'h1C, 32'h6000);
    for (int i = 0; i < 7; i++)
    begin
      fr(m, 48'h5, 1'b1, 4'h0, {i % 3 == 0, 2'b0});
      fr(48'h5, 48'h5, 1'b1, 4'h0, 3'h0);
    end
    wr(8'h1E, 32'h1);
    for (int i = 0; i < 3; i++)
      fr(m, 48'h5, 1'b1, 4'h0, {i != 1, 2'b0});
    wr(8'h1C, 32'h4000);
    fr(m, 48'h5, 1'b1, 4'h0, 3'h4);
    fr(m, 48'h5, 1'b1, 4'h0, 3'h4);
  endtask
  task automatic s_reset;
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd(8'h50, 32'hFFFFFFFF, 32'h0);
    rd(8'h20, 32'hFFFFFFFF, 32'h0);
    fr(m, m, 1'b1, 4'h1, 3'h4);
  endtask
  task automatic end_of_test;
    if (failures == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    s_regs;
    s_snoop;
    s_mirror;
    s_reset;
    end_of_test;
  end
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    end_of_test;
  end
endmodule // mssc_bank_test
bind mssc_bank mssc_bank_sva u_mssc_bank_sva (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .frame_valid(frame_valid), .frame_port_sel(frame_port_sel), .is_igmp_query(is_igmp_query),
  .is_igmp_unknown(is_igmp_unknown), .is_mld_query(is_mld_query), .is_mld_report_done(is_mld_report_done),
  .mirror_out(mirror_out), .copy_to_cpu(copy_to_cpu), .cpu_only(cpu_only));
